// ===== shared/csd_defines.svh
// Constants for the chip-select decoder
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
`define CSD_ADDR_W 20
`define CSD_UPPER_RST_LO 20'hFFC00
`define CSD_UPPER_RST_HI 20'hFFFFF
`define CSD_UPPER_RST_MEM 1'h1
`define CSD_UPPER_RST_IO 1'h0
`define CSD_LOWER_RST_EN 1'h0
`define CSD_GEN_RST_EN 8'h00
`define CSD_PORT1_RST 8'hFF
`define CSD_NUM_GEN 8
`endif

// ===== shared/csd_match_if.sv
// Address and cycle type carried to the range comparator
`timescale 1ns/1ps
interface csd_match_if;
  logic [19:0] addr;
  logic is_io;
  logic active;
  modport src (output addr, output is_io, output active);
  modport dst (input addr, input is_io, input active);
endinterface

// ===== shared/csd_pkg.sv
// Types for the chip-select decoder
package csd_pkg;
  typedef enum logic [2:0] {
    CSD_IDLE = 3'h1,
    CSD_ACTIVE = 3'h2,
    CSD_DONE = 3'h4
  } csd_state_e;

  typedef struct packed {
    logic [19:0] lo;
    logic [19:0] hi;
    logic mem_en;
    logic io_en;
    logic no_ready;
  } csd_range_s;
endpackage

// ===== src/csd_decode.sv
// Chip-select decoder top
// Contract
// - Upper select asserts for bus cycles inside its programmed range, except cycles ended without waiting for ready.
// - After reset upper select covers memory FFC00 to FFFFF without programming.
// - Lower select asserts for bus cycles inside its programmed range, except cycles ended without waiting for ready.
// - Lower select stays inactive after reset until programmed.
// - Each enabled general select asserts for cycles inside its limits, except cycles ended without waiting for ready.
// - A general pin not used as select drives its port1 output bit.
// - Bus cycles end on ready unless the matching select ignores ready.
`timescale 1ns/1ps
`include "csd_defines.svh"
module csd_decode (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CYC_START_I,
  input wire logic CYC_IO_I,
  input wire logic [19:0] CYC_ADDR_I,
  input wire logic READY_I,
  input wire logic CFG_WE_I,
  input wire logic [3:0] CFG_SEL_I,
  input wire logic [19:0] CFG_LO_I,
  input wire logic [19:0] CFG_HI_I,
  input wire logic CFG_MEM_I,
  input wire logic CFG_IO_I,
  input wire logic CFG_NORDY_I,
  input wire logic CFG_EN_I,
  input wire logic [7:0] PORT1_DATA_I,
  output logic UPPER_SELECT_N_O,
  output logic LOWER_SELECT_N_O,
  output logic [7:0] GENERAL_SELECT_N_O,
  output logic CYC_END_O
);
  // ***************************
  // State
  // ***************************
  typedef struct packed {
    csd_pkg::csd_state_e st;
    logic [19:0] addr;
    logic is_io;
    logic rdy_s1;
    logic rdy_s2;
    csd_pkg::csd_range_s up;
    csd_pkg::csd_range_s low;
    logic low_en;
    csd_pkg::csd_range_s [`CSD_NUM_GEN-1:0] gen;
    logic [7:0] gen_en;
    logic up_n;
    logic low_n;
    logic [7:0] gen_n;
    logic cyc_end;
  } csd_state_s;

  csd_state_s state_r;
  csd_state_s state_nxt;
  csd_match_if mbus ();
  logic up_hit;
  logic low_hit;
  logic [7:0] gen_hit;

  // ***************************
  // Comparator bus
  // ***************************
  assign mbus.addr = state_r.addr;
  assign mbus.is_io = state_r.is_io;
  assign mbus.active = (state_r.st == csd_pkg::CSD_ACTIVE);

  // ***************************
  // Range comparators
  // ***************************
  csd_range_cmp u_up (
    .bus(mbus),
    .range_i(state_r.up),
    .enable_i(1'h1),
    .hit_o(up_hit)
  );
  csd_range_cmp u_low (
    .bus(mbus),
    .range_i(state_r.low),
    .enable_i(state_r.low_en),
    .hit_o(low_hit)
  );
  genvar gi;
  generate
    for (gi = 0; gi < `CSD_NUM_GEN; gi++) begin : g_gen
      csd_range_cmp u_gen (
        .bus(mbus),
        .range_i(state_r.gen[gi]),
        .enable_i(state_r.gen_en[gi]),
        .hit_o(gen_hit[gi])
      );
    end
  endgenerate

  // ***************************
  // Next state
  // ***************************
  always_comb begin
    logic ignore_rdy;
    logic [2:0] gen_idx;
    ignore_rdy = 1'h0;
    gen_idx = CFG_SEL_I[2:0] - 3'h2;
    state_nxt = state_r;
    state_nxt.rdy_s1 = READY_I;
    state_nxt.rdy_s2 = state_r.rdy_s1;
    state_nxt.cyc_end = 1'h0;

    // ***************************
    // Configuration writes
    // ***************************
    if (CFG_WE_I) begin
      case (CFG_SEL_I)
        4'h0: begin
          state_nxt.up.lo = CFG_LO_I;
          state_nxt.up.hi = CFG_HI_I;
          state_nxt.up.mem_en = CFG_MEM_I;
          state_nxt.up.io_en = CFG_IO_I;
          state_nxt.up.no_ready = CFG_NORDY_I;
        end
        4'h1: begin
          state_nxt.low.lo = CFG_LO_I;
          state_nxt.low.hi = CFG_HI_I;
          state_nxt.low.mem_en = CFG_MEM_I;
          state_nxt.low.io_en = CFG_IO_I;
          state_nxt.low.no_ready = CFG_NORDY_I;
          state_nxt.low_en = CFG_EN_I;
        end
        default: begin
          if (CFG_SEL_I >= 4'h2 && CFG_SEL_I <= 4'h9) begin
            state_nxt.gen[gen_idx].lo = CFG_LO_I;
            state_nxt.gen[gen_idx].hi = CFG_HI_I;
            state_nxt.gen[gen_idx].mem_en = CFG_MEM_I;
            state_nxt.gen[gen_idx].io_en = CFG_IO_I;
            state_nxt.gen[gen_idx].no_ready = CFG_NORDY_I;
            state_nxt.gen_en[gen_idx] = CFG_EN_I;
          end
        end
      endcase
    end

    // ***************************
    // Cycle sequencing
    // ***************************
    case (state_r.st)
      csd_pkg::CSD_IDLE: begin
        if (CYC_START_I) begin
          state_nxt.addr = CYC_ADDR_I;
          state_nxt.is_io = CYC_IO_I;
          state_nxt.st = csd_pkg::CSD_ACTIVE;
        end
      end
      csd_pkg::CSD_ACTIVE: begin
        if (up_hit && state_r.up.no_ready) begin
          ignore_rdy = 1'h1;
        end
        if (low_hit && state_r.low.no_ready) begin
          ignore_rdy = 1'h1;
        end
        for (int i = 0; i < `CSD_NUM_GEN; i++) begin
          if (gen_hit[i] && state_r.gen[i].no_ready) begin
            ignore_rdy = 1'h1;
          end
        end
        if (ignore_rdy || state_r.rdy_s2) begin
          state_nxt.st = csd_pkg::CSD_DONE;
          state_nxt.cyc_end = 1'h1;
        end
      end
      csd_pkg::CSD_DONE: begin
        state_nxt.st = csd_pkg::CSD_IDLE;
      end
      default: begin
        state_nxt.st = csd_pkg::CSD_IDLE;
      end
    endcase

    // ***************************
    // Select outputs
    // ***************************
    state_nxt.up_n = 1'h1;
    state_nxt.low_n = 1'h1;
    if (state_nxt.st == csd_pkg::CSD_ACTIVE && state_r.st == csd_pkg::CSD_ACTIVE) begin
      state_nxt.up_n = ~up_hit;
      state_nxt.low_n = ~low_hit;
    end
    for (int i = 0; i < `CSD_NUM_GEN; i++) begin
      if (!state_r.gen_en[i]) begin
        state_nxt.gen_n[i] = PORT1_DATA_I[i];
      end else if (state_nxt.st == csd_pkg::CSD_ACTIVE && state_r.st == csd_pkg::CSD_ACTIVE) begin
        state_nxt.gen_n[i] = ~gen_hit[i];
      end else begin
        state_nxt.gen_n[i] = 1'h1;
      end
    end
  end

  // ***************************
  // Registers
  // ***************************
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= '0;
      state_r.st <= csd_pkg::CSD_IDLE;
      state_r.up.lo <= `CSD_UPPER_RST_LO;
      state_r.up.hi <= `CSD_UPPER_RST_HI;
      state_r.up.mem_en <= `CSD_UPPER_RST_MEM;
      state_r.up.io_en <= `CSD_UPPER_RST_IO;
      state_r.up.no_ready <= 1'h0;
      state_r.low_en <= `CSD_LOWER_RST_EN;
      state_r.gen_en <= `CSD_GEN_RST_EN;
      state_r.up_n <= 1'h1;
      state_r.low_n <= 1'h1;
      state_r.gen_n <= `CSD_PORT1_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************
  // Output drive
  // ***************************
  assign UPPER_SELECT_N_O = state_r.up_n;
  assign LOWER_SELECT_N_O = state_r.low_n;
  assign GENERAL_SELECT_N_O = state_r.gen_n;
  assign CYC_END_O = state_r.cyc_end;
endmodule

// ===== src/csd_range_cmp.sv
// Combinational comparator of one address against one range
`timescale 1ns/1ps
module csd_range_cmp (
  csd_match_if.dst bus,
  input wire csd_pkg::csd_range_s range_i,
  input wire logic enable_i,
  output logic hit_o
);
  always_comb begin
    hit_o = enable_i && bus.active && (bus.addr >= range_i.lo) && (bus.addr <= range_i.hi) &&
            (bus.is_io ? range_i.io_en : range_i.mem_en);
  end
endmodule

// ===== verification/csd_decode_asserts.sv
// Port assertions for the chip-select decoder
`timescale 1ns/1ps
module csd_decode_asserts (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CYC_START_I,
  input wire logic READY_I,
  input wire logic CFG_WE_I,
  input wire logic [3:0] CFG_SEL_I,
  input wire logic UPPER_SELECT_N_O,
  input wire logic LOWER_SELECT_N_O,
  input wire logic CYC_END_O
);
  logic lo_set_r;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) lo_set_r <= 1'h0;
    else if (CFG_WE_I && CFG_SEL_I == 4'h1) lo_set_r <= 1'h1;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  property p_e1; CYC_END_O |=> !CYC_END_O; endproperty
  a_e1: assert property (p_e1) else $error("end too long");
  property p_eh; CYC_END_O |-> UPPER_SELECT_N_O && LOWER_SELECT_N_O; endproperty
  a_eh: assert property (p_eh) else $error("select at end");
  property p_uf; $fell(UPPER_SELECT_N_O) |-> $past(CYC_START_I, 2) || $past(CYC_START_I, 3); endproperty
  a_uf: assert property (p_uf) else $error("upper no cycle");
  property p_lf; $fell(LOWER_SELECT_N_O) |-> $past(CYC_START_I, 2) || $past(CYC_START_I, 3); endproperty
  a_lf: assert property (p_lf) else $error("lower no cycle");
  property p_ur; $rose(UPPER_SELECT_N_O) |-> CYC_END_O; endproperty
  a_ur: assert property (p_ur) else $error("upper early");
  property p_lr; $rose(LOWER_SELECT_N_O) |-> CYC_END_O; endproperty
  a_lr: assert property (p_lr) else $error("lower early");
  property p_ls; !lo_set_r |-> LOWER_SELECT_N_O; endproperty
  a_ls: assert property (p_ls) else $error("lower unset");
  property p_rd; CYC_END_O |-> $past(READY_I, 2) || $past(CYC_START_I, 2) || $past(CYC_START_I, 3); endproperty
  a_rd: assert property (p_rd) else $error("end no ready");
  cover property (CYC_END_O);
  cover property ($fell(UPPER_SELECT_N_O));
  cover property ($fell(LOWER_SELECT_N_O));
endmodule
bind csd_decode csd_decode_asserts csd_decode_asserts_inst (.*);

// ===== verification/csd_decode_tb.sv
// Self-checking bench for the chip-select decoder
`timescale 1ns/1ps
module csd_decode_tb;
  logic clk = 1'h0, rst = 1'h1, st = 1'h0, io = 1'h0, we = 1'h0, rdy, us, ls, ce;
  logic [19:0] a = 20'h00000, lo = 20'h00000, hi = 20'h00000;
  logic [3:0] sel = 4'h0, m4 = 4'h0, wt = 4'h4;
  logic [7:0] p1 = 8'hFF, gs;
  logic [9:0] seen;
  int errors = 0, comparisons = 0, cyc = 0;
  int mlo[10] = '{0: 'hFFC00, default: 0}, mhi[10] = '{0: 'hFFFFF, default: 0}, mm[10] = '{0: 10, default: 0};
  initial forever #50 clk = ~clk;
  csd_decode csd_decode_inst (.MCLK_I(clk), .RST_I(rst), .CYC_START_I(st), .CYC_IO_I(io), .CYC_ADDR_I(a),
    .READY_I(rdy), .CFG_WE_I(we), .CFG_SEL_I(sel), .CFG_LO_I(lo), .CFG_HI_I(hi), .CFG_MEM_I(m4[1]),
    .CFG_IO_I(m4[0]), .CFG_NORDY_I(m4[2]), .CFG_EN_I(m4[3]), .PORT1_DATA_I(p1), .UPPER_SELECT_N_O(us),
    .LOWER_SELECT_N_O(ls), .GENERAL_SELECT_N_O(gs), .CYC_END_O(ce));
  csd_ready_model csd_ready_model_inst (.clk_i(clk), .start_i(st), .end_i(ce), .wait_i(wt), .ready_o(rdy));
  task automatic chk(input logic [9:0] g, input logic [9:0] x);
    comparisons++;
    if (g !== x) begin
      errors++;
      $display("Error %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cfg(input int k, input int l, input int h, input int m);
    @(negedge clk);
    {we, sel, lo, hi, m4} = {1'h1, 4'(k), 20'(l), 20'(h), 4'(m)};
    mlo[k] = l;
    mhi[k] = h;
    mm[k] = k ? m : m | 8;
    @(negedge clk);
    we = 1'h0;
  endtask
  task automatic run(input int ad, input int i);
    logic [9:0] e;
    logic nr;
    int t;
    e = 10'h000;
    nr = 1'h0;
    for (int k = 0; k < 10; k++) begin
      e[k] = mm[k][3] && mm[k][1 - i] && ad >= mlo[k] && ad <= mhi[k];
      nr |= e[k] && mm[k][2];
    end
    @(negedge clk);
    {st, a, io} = {1'h1, 20'(ad), 1'(i)};
    @(negedge clk);
    st = 1'h0;
    seen = 10'h000;
    for (t = 0; ce !== 1'h1 && t < 30; t++) begin
      @(negedge clk);
      seen |= ~{gs, ls, us};
    end
    chk(seen, nr ? 10'h000 : e);
    chk(10'(t < 4), 10'(nr));
    @(negedge clk);
    chk({gs, ls, us}, 10'h3FF);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h7de3));
    repeat (2) @(negedge clk);
    rst = 1'h0;
    run('hFFC00, 0);
    run('hFFFFF, 0);
    run('hFFBFF, 0);
    run('hFFC00, 1);
    run('h00000, 0);
    cfg(1, 0, 'h3FF, 11);
    run('h3FF, 1);
    run('h400, 0);
    cfg(0, 'h80000, 'h8FFFF, 10);
    run('h80000, 0);
    run('hFFC00, 0);
    for (int k = 0; k < 8; k++) begin
      cfg(k + 2, 'h10000 + k * 'h1000, 'h10FFF + k * 'h1000, k % 3 + 1 + (k % 2 ? 0 : 8));
      run('h10000 + k * 'h1000 + $urandom_range('hFFF), $urandom_range(1));
    end
    cfg(9, 'h20000, 'h20000, 15);
    run('h20000, 0);
    repeat (6) begin
      @(negedge clk);
      p1 = 8'($urandom);
      @(negedge clk);
      chk(10'(gs), 10'(p1 | 8'hD5));
    end
    p1 = 8'($urandom);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    for (int k = 0; k < 10; k++) begin
      mm[k] = k ? 0 : 10;
    end
    mlo[0] = 'hFFC00;
    mhi[0] = 'hFFFFF;
    @(negedge clk);
    chk(10'(gs), 10'(p1));
    p1 = 8'hFF;
    run('hFFC00, 0);
    run('h3FF, 1);
    run('h10000, 0);
    tally_and_finish;
  end
endmodule

// ===== verification/csd_ready_model.sv
// Memory that answers a bus cycle with ready after a wait
`timescale 1ns/1ps
module csd_ready_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic end_i,
  input wire logic [3:0] wait_i,
  output logic ready_o
);
  logic [3:0] cnt = 4'h0;
  initial ready_o = 1'h0;
  always @(posedge clk_i) begin
    ready_o <= !end_i && (ready_o || cnt == 4'h1);
    cnt <= start_i ? wait_i : (end_i || cnt == 4'h0 ? 4'h0 : cnt - 4'h1);
  end
endmodule
